// ---- pkg/aksp_pkg.sv ----
// Package of constants for the keyboard strobe receiver and its register bank.
// Function
// [RULE_01] The keyboard drives an 8-bit character code in which bit 6 comes in two versions.
// [RULE_02] Data lines may change freely outside the strobe-valid interval.
// [RULE_03] The receiver ignores data unless the strobe is asserted and accepts a character only then.
// [RULE_04] The keyboard holds its strobe as a level for as long as the code is valid.
// [RULE_05] A polarity strap inverts data and strobe together, and the receiver decodes that polarity.
// [RULE_06] The receiver uses one of the two bit 6 forms, chosen by a case-lock switch.
// [RULE_07] Parity checking is optional and uses the sense chosen by the parity select.
// [RULE_08] A receiver wanting an edge strobe derives one pulse, about 1 ms wide, from the level.
// [RULE_09] The repeat, break and answerback keys give no code and are bare contacts.
// [RULE_10] The receiver latches the code exactly once per strobe assertion, on its leading edge.
package aksp_pkg;
  localparam int unsigned AKSP_CLK_HZ = 10_000_000;
  localparam int unsigned AKSP_PULSE_US = 1000;
  localparam int unsigned AKSP_PULSE_CYC = AKSP_CLK_HZ / 1_000_000 * AKSP_PULSE_US;
  // Register word offsets (byte addresses).
  localparam logic [3:0] AKSP_REG_CTRL = 4'h0;
  localparam logic [3:0] AKSP_REG_DATA = 4'h4;
  localparam logic [3:0] AKSP_REG_STAT = 4'h8;
  // Control fields.
  localparam int unsigned AKSP_CTRL_NEG = 0;
  localparam int unsigned AKSP_CTRL_LOCK = 1;
  localparam int unsigned AKSP_CTRL_PAREN = 2;
  localparam int unsigned AKSP_CTRL_PARODD = 3;
  localparam logic [3:0] AKSP_CTRL_RST = 4'h0;
  // Status fields.
  localparam int unsigned AKSP_STAT_AVAIL = 0;
  localparam int unsigned AKSP_STAT_OVR = 1;
  localparam int unsigned AKSP_STAT_PERR = 2;
  localparam int unsigned AKSP_STAT_STB = 3;
  localparam int unsigned AKSP_STAT_PULSE = 4;
endpackage

// ---- design/aksp_receiver.sv ----
// Host-side receiver for a level-strobed parallel keyboard, with a Wishbone register bank.
`timescale 1ns/1ps
`default_nettype none
module aksp_receiver #(
  parameter int unsigned PULSE_CYC = aksp_pkg::AKSP_PULSE_CYC
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Wishbone slave.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Keyboard pins.
  input wire logic [7:0] kbd_data_in,
  input wire logic bit6_mixed_case_in,
  input wire logic bit6_upper_only_in,
  input wire logic kbd_parity_in,
  input wire logic kbd_strobe_in,
  // Strap driven toward the keyboard.
  output logic kbd_invert_out,
  // Derived edge strobe.
  output logic key_pulse_out
);
  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin
      $error("PULSE_CYC out of range");
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [10:0] s1_q, s2_q, s1_d, s2_d;
  always_comb begin
    s1_d = {kbd_strobe_in, kbd_parity_in, bit6_upper_only_in, bit6_mixed_case_in,
            kbd_data_in[7], kbd_data_in[5:0]};
    s2_d = s1_q;
  end
  always_ff @(posedge ref_clk_in) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
  end

  // ****************************************
  // Registers and capture
  // ****************************************
  logic [3:0] ctrl_q, ctrl_d;
  logic [7:0] code_q, code_d;
  logic avail_q, avail_d, ovr_q, ovr_d, perr_q, perr_d, stb_prev_q, stb_prev_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [15:0] pcnt_q, pcnt_d;
  logic pulse_q, pulse_d;
  logic [10:0] pins;
  logic stb_now, rise, rd_data, wr_ctrl, b6;
  logic [7:0] code_new;

  always_comb begin
    // Both data and strobe are inverted when the negative-logic strap is set.
    pins = s2_q ^ {11{ctrl_q[aksp_pkg::AKSP_CTRL_NEG]}}; // see [RULE_05]
    stb_now = pins[10]; // see [RULE_04]
    rise = stb_now && !stb_prev_q; // see [RULE_10]
    b6 = ctrl_q[aksp_pkg::AKSP_CTRL_LOCK] ? pins[8] : pins[7]; // see [RULE_06]
    code_new = {pins[6], b6, pins[5:0]}; // see [RULE_01]
    wr_ctrl = wb_cyc_in && wb_stb_in && !ack_q && wb_we_in
              && wb_adr_in == aksp_pkg::AKSP_REG_CTRL && wb_sel_in[0];
    rd_data = wb_cyc_in && wb_stb_in && !ack_q && !wb_we_in
              && wb_adr_in == aksp_pkg::AKSP_REG_DATA;
    stb_prev_d = stb_now;
    ctrl_d = wr_ctrl ? wb_dat_in[3:0] : ctrl_q;
    code_d = code_q;
    avail_d = avail_q;
    ovr_d = ovr_q;
    perr_d = perr_q;
    // Reading data clears flags; a capture in the same cycle wins.
    if (rd_data) begin
      avail_d = 1'b0;
      ovr_d = 1'b0;
      perr_d = 1'b0;
    end
    // Data is only looked at on the strobe's leading edge, so wander between keys is harmless.
    if (rise) begin // see [RULE_03] see [RULE_02]
      code_d = code_new;
      avail_d = 1'b1;
      ovr_d = avail_q && !rd_data;
      perr_d = ctrl_q[aksp_pkg::AKSP_CTRL_PAREN]
               && ((^code_new ^ pins[9]) != ctrl_q[aksp_pkg::AKSP_CTRL_PARODD]); // see [RULE_07]
    end
    pcnt_d = pcnt_q;
    pulse_d = pulse_q;
    if (rise) begin // see [RULE_08]
      pcnt_d = 16'(PULSE_CYC - 1);
      pulse_d = 1'b1;
    end else if (pcnt_q != 16'h0000) begin
      pcnt_d = pcnt_q - 16'h0001;
    end else begin
      pulse_d = 1'b0;
    end
    ack_d = wb_cyc_in && wb_stb_in && !ack_q;
    rdat_d = 32'h0000_0000;
    unique case (wb_adr_in)
      aksp_pkg::AKSP_REG_CTRL: rdat_d[3:0] = ctrl_q;
      aksp_pkg::AKSP_REG_DATA: rdat_d[7:0] = code_q;
      aksp_pkg::AKSP_REG_STAT: rdat_d[4:0] = {pulse_q, stb_now, perr_q, ovr_q, avail_q};
      default: rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl_q <= aksp_pkg::AKSP_CTRL_RST;
      code_q <= 8'h00;
      avail_q <= 1'b0;
      ovr_q <= 1'b0;
      perr_q <= 1'b0;
      stb_prev_q <= 1'b1;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      pcnt_q <= 16'h0000;
      pulse_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      code_q <= code_d;
      avail_q <= avail_d;
      ovr_q <= ovr_d;
      perr_q <= perr_d;
      stb_prev_q <= stb_prev_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      pcnt_q <= pcnt_d;
      pulse_q <= pulse_d;
    end
  end

  always_comb begin
    wb_ack_out = ack_q;
    wb_dat_out = rdat_q;
    kbd_invert_out = ctrl_q[aksp_pkg::AKSP_CTRL_NEG];
    key_pulse_out = pulse_q;
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_CAPTURE_ON_EDGE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise |=> avail_q && code_q == $past(code_new)) // see [RULE_10]
    else $error("code not captured on strobe edge");
  AST_NO_CAPTURE_WITHOUT_EDGE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !rise |=> code_q == $past(code_q)) // see [RULE_03]
    else $error("code changed without strobe edge");
  AST_PULSE_START: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise |=> pulse_q) // see [RULE_08]
    else $error("pulse did not start");
  AST_INVERT_FOLLOWS: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    kbd_invert_out == ctrl_q[aksp_pkg::AKSP_CTRL_NEG]) // see [RULE_05]
    else $error("invert strap mismatch");
  AST_CASE_SELECT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise && ctrl_q[aksp_pkg::AKSP_CTRL_LOCK] |=> code_q[6] == $past(pins[8])) // see [RULE_06]
    else $error("case lock not applied");
  AST_NO_PERR_OFF: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise && !ctrl_q[aksp_pkg::AKSP_CTRL_PAREN] |=> !perr_q) // see [RULE_07]
    else $error("parity error while disabled");
  AST_ACK_ONE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");
  AST_ACK_TIMING: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");

  // ****************************************
  // Flag, pulse and register checks
  // ****************************************
  // A second key before software reads the first must be reported, because
  // the first code is overwritten and would otherwise vanish silently.
  AST_OVR_ON_SECOND: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise && avail_q && !rd_data |=> ovr_q) // see [RULE_10]
    else $error("overrun not flagged");
  AST_READ_CLEARS: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rd_data && !rise |=> !avail_q && !ovr_q && !perr_q)
    else $error("data read did not clear flags");
  AST_CAPTURE_WINS: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rd_data && rise |=> avail_q && !ovr_q) // see [RULE_10]
    else $error("capture lost to read");
  AST_NO_EDGE_WHEN_LOW: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !stb_now |-> !rise) // see [RULE_03]
    else $error("edge seen while strobe low");
  AST_PULSE_HOLD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    pulse_q && pcnt_q != 16'h0000 |=> pulse_q) // see [RULE_08]
    else $error("pulse ended early");
  AST_PULSE_END: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    pulse_q && pcnt_q == 16'h0000 && !rise |=> !pulse_q) // see [RULE_08]
    else $error("pulse ran too long");
  AST_NO_PULSE_START: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !pulse_q && !rise |=> !pulse_q) // see [RULE_08]
    else $error("pulse without strobe edge");
  AST_CASE_MIXED: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise && !ctrl_q[aksp_pkg::AKSP_CTRL_LOCK] |=> code_q[6] == $past(pins[7])) // see [RULE_06]
    else $error("mixed case bit not used");
  AST_PERR_CLEAN: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rise && ((^code_new ^ pins[9]) == ctrl_q[aksp_pkg::AKSP_CTRL_PARODD]) |=> !perr_q) // see [RULE_07]
    else $error("parity error on good parity");
  AST_CTRL_WRITE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wr_ctrl |=> ctrl_q == $past(wb_dat_in[3:0])) // see [RULE_05]
    else $error("control write lost");
  AST_DATA_READ: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    rd_data |=> wb_dat_out[7:0] == $past(code_q)) // see [RULE_01]
    else $error("data read returned wrong code");
endmodule
`default_nettype wire

// ---- sim/aksp_kbd_model.sv ----
// Behavioural keyboard with level strobe, polarity strap and two bit-6 pins.
`timescale 1ns/1ps
`default_nettype none
module aksp_kbd_model (
  // Bench controls.
  input wire logic ref_clk_in,
  input wire logic invert_in,
  input wire logic press_in,
  input wire logic [7:0] code_in,
  input wire logic alt6_in,
  input wire logic par_in,
  // Keyboard pins.
  output logic [7:0] data_out,
  output logic b6a_out,
  output logic b6b_out,
  output logic par_out,
  output logic stb_out
);
  logic [7:0] junk_q = 8'hA5;
  logic [7:0] v;
  // Idle lines wander every cycle, so a receiver that ignores the strobe is caught.
  always @(posedge ref_clk_in) junk_q <= junk_q + 8'h5B;
  assign v = press_in ? code_in : junk_q;
  assign data_out = v ^ {8{invert_in}};
  assign b6a_out = v[6] ^ invert_in;
  assign b6b_out = (press_in ? alt6_in : ~junk_q[6]) ^ invert_in;
  assign par_out = (press_in ? par_in : junk_q[0]) ^ invert_in;
  assign stb_out = press_in ^ invert_in;
  // Repeat, break and answerback contacts give no code, so no pin carries them.
endmodule
`default_nettype wire

// ---- sim/ascii_keyboard_strobe_port_bench.sv ----
// Self-checking bench for the keyboard strobe receiver.
`timescale 1ns/1ps
`default_nettype none
module ascii_keyboard_strobe_port_bench;
  localparam int unsigned PC = 5;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, press = 1'b0;
  logic alt6 = 1'b0, kpar = 1'b0, ack, inv, pulse, b6a, b6b, par, kstb;
  logic [3:0] adr = 4'h0;
  logic [7:0] code = 8'h00, kdat;
  logic [31:0] wdat = 32'h0, rdat, q;
  int fails = 0, n_compared = 0, seed = 32'h0F049434, e;
  initial forever #50 clk = ~clk;
  aksp_receiver #(.PULSE_CYC(PC)) dut (.ref_clk_in(clk), .srst_in(srst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .kbd_data_in(kdat), .bit6_mixed_case_in(b6a),
    .bit6_upper_only_in(b6b), .kbd_parity_in(par), .kbd_strobe_in(kstb),
    .kbd_invert_out(inv), .key_pulse_out(pulse));
  aksp_kbd_model kbd (.ref_clk_in(clk), .invert_in(inv), .press_in(press), .code_in(code),
    .alt6_in(alt6), .par_in(kpar), .data_out(kdat), .b6a_out(b6a), .b6b_out(b6b),
    .par_out(par), .stb_out(kstb));
  task automatic close_out;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      fails++;
      close_out();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // A fresh mode is followed by a data read so that any edge seen while the
  // strap flipped is discarded before the next key.
  task automatic settle(input logic [31:0] c);
    wb(1'b1, aksp_pkg::AKSP_REG_CTRL, c);
    press <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, aksp_pkg::AKSP_REG_DATA, 32'h0);
  endtask
  task automatic key(input logic [7:0] c, input logic a6, input logic bad);
    code <= c;
    alt6 <= a6;
    kpar <= ^c ^ bad;
    press <= 1'b1;
    repeat (4) @(posedge clk);
    chk(pulse, 32'h1);
    repeat (PC + 1) @(posedge clk);
    chk(pulse, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wb(1'b0, aksp_pkg::AKSP_REG_CTRL, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    for (int m = 0; m < 4; m++) begin
      settle(m);
      chk(inv, m[0]);
      wb(1'b0, aksp_pkg::AKSP_REG_STAT, 32'h0);
      chk(q & 32'h1F, 32'h0);
      e = $random(seed);
      key(e[7:0], e[8], 1'b0);
      repeat (20) @(posedge clk);
      wb(1'b0, aksp_pkg::AKSP_REG_STAT, 32'h0);
      chk(q & 32'h1F, 32'h09);
      wb(1'b0, aksp_pkg::AKSP_REG_DATA, 32'h0);
      chk(q & 32'hFF, {24'h0, e[7], m[1] ? e[8] : e[6], e[5:0]});
    end
    for (int p = 0; p < 4; p++) begin
      settle({28'h0, p[1], 3'h4});
      e = $random(seed);
      key(e[7:0], 1'b0, p[0]);
      wb(1'b0, aksp_pkg::AKSP_REG_STAT, 32'h0);
      chk(q & 32'h1F, {27'h0, 2'h1, p[0] ^ p[1], 2'h1});
    end
    settle(32'h0);
    key(8'h41, 1'b0, 1'b0);
    press <= 1'b0;
    repeat (4) @(posedge clk);
    key(8'h43, 1'b0, 1'b0);
    wb(1'b0, aksp_pkg::AKSP_REG_STAT, 32'h0);
    chk(q & 32'h1F, 32'h0B);
    wb(1'b0, aksp_pkg::AKSP_REG_DATA, 32'h0);
    chk(q & 32'hFF, 32'h43);
    close_out();
  end
endmodule
`default_nettype wire
